// ---- core/vdlc_pkg.sv ----
// holds constants for the lock and analog input control registers
// assumes a byte wide register access decoded from the serial port
package vdlc_pkg;
  localparam int          ADDR_W        = 8;
  localparam logic [7:0]  LOCK_CTRL_OFS = 8'h04;
  localparam logic [7:0]  AIN_CTRL_OFS  = 8'h05;
  localparam logic [7:0]  LOCK_CTRL_RST = 8'h09;
  localparam logic [7:0]  AIN_CTRL_RST  = 8'h10;
  // sync_lock_control fields
  localparam int          ASPECT_BIT    = 7;
  localparam int          FREEZE_BIT    = 6;
  localparam int          DUTY_BIT      = 5;
  localparam int          LTC_BIT       = 4;
  localparam int          HMISS_BIT     = 3;
  localparam int          VMISS_BIT     = 2;
  localparam int          CLKF_LSB      = 0;
  // analog_input_control fields
  localparam int          POLICY_LSB    = 6;
  localparam int          GAIN_LSB      = 4;
  localparam int          AAF_BIT       = 3;
  localparam int          INSEL_LSB     = 0;
  // missing sync thresholds
  localparam logic [3:0]  HMISS_MANY    = 4'hc;
  localparam logic [1:0]  VMISS_MANY    = 2'h3;
  typedef enum logic [1:0] {
    VDLC_GAIN_UNITY, VDLC_GAIN_AUTO, VDLC_GAIN_FIXED, VDLC_GAIN_FREEZE
  } vdlc_gain_t;
  typedef enum logic [1:0] {
    VDLC_LOSS_AUTO, VDLC_LOSS_KEEP, VDLC_LOSS_AGC_THEN_FIX, VDLC_LOSS_RSVD
  } vdlc_policy_t;
  typedef enum logic [2:0] {
    VDLC_FMT_YC16, VDLC_FMT_YC8, VDLC_FMT_BYTE_SER, VDLC_FMT_RGB15,
    VDLC_FMT_RGB16, VDLC_FMT_R5, VDLC_FMT_R6, VDLC_FMT_R7
  } vdlc_fmt_t;
endpackage

// ---- core/vdlc_lock_if.sv ----
// carries missing sync thresholds and lock acquisition events
// assumes both ends run on sys_clk
`timescale 1ns/10ps
`default_nettype none
interface vdlc_lock_if;
  logic h_one;
  logic v_one;
  logic h_acq;
  logic v_acq;
  modport ctrl (output h_one, output v_one, input h_acq, input v_acq);
  modport mon  (input h_one, input v_one, output h_acq, output v_acq);
endinterface
`default_nettype wire

// ---- core/vdlc_lock_mon.sv ----
// counts missing horizontal and vertical sync pulses
// assumes miss and seen strobes come from logic on sys_clk
`timescale 1ns/10ps
`default_nettype none
module vdlc_lock_mon (
  input  wire logic sys_clk,
  input  wire logic rst_n,
  input  wire logic hsync_miss,
  input  wire logic hsync_seen,
  input  wire logic vsync_miss,
  input  wire logic vsync_seen,
  vdlc_lock_if.mon  lk
);
  import vdlc_pkg::*;

  typedef struct packed {
    logic [3:0] h_cnt;
    logic [1:0] v_cnt;
    logic       h_acq;
    logic       v_acq;
  } vdlc_mon_st_t;

  vdlc_mon_st_t st_q;
  vdlc_mon_st_t st_d;
  logic [3:0]   h_thr;
  logic [1:0]   v_thr;

  assign h_thr = lk.h_one ? 4'h1 : HMISS_MANY;
  assign v_thr = lk.v_one ? 2'h1 : VMISS_MANY;
  assign lk.h_acq = st_q.h_acq;
  assign lk.v_acq = st_q.v_acq;

  always_comb begin
    st_d       = st_q;
    st_d.h_acq = 1'b0;
    st_d.v_acq = 1'b0;
    if (hsync_seen) begin
      st_d.h_cnt = 4'h0;
    end else if (hsync_miss) begin
      if (st_q.h_cnt + 4'h1 >= h_thr) begin
        st_d.h_acq = 1'b1;
        st_d.h_cnt = 4'h0;
      end else begin
        st_d.h_cnt = st_q.h_cnt + 4'h1;
      end
    end
    if (vsync_seen) begin
      st_d.v_cnt = 2'h0;
    end else if (vsync_miss) begin
      if (st_q.v_cnt + 2'h1 >= v_thr) begin
        st_d.v_acq = 1'b1;
        st_d.v_cnt = 2'h0;
      end else begin
        st_d.v_cnt = st_q.v_cnt + 2'h1;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  h_single_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    lk.h_one && hsync_miss && !hsync_seen |=> lk.h_acq)
    else $error("single missing hsync did not start acquisition");
  h_twelfth_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    !lk.h_one && st_q.h_cnt == 4'hb && hsync_miss && !hsync_seen
    |=> lk.h_acq)
    else $error("twelfth missing hsync did not start acquisition");
  v_third_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    !lk.v_one && st_q.v_cnt == 2'h2 && vsync_miss && !vsync_seen
    |=> lk.v_acq)
    else $error("third missing vsync did not start acquisition");
endmodule
`default_nettype wire

// ---- core/vdlc_top.sv ----
// lock control and analog input control registers with their effects
// assumes the serial port engine delivers decoded byte reads and writes
`timescale 1ns/10ps
`default_nettype none
module vdlc_top (
  input  wire logic                          sys_clk,
  input  wire logic                          rst_n,
  input  wire logic                          reg_wr,
  input  wire logic                          reg_rd,
  input  wire logic [vdlc_pkg::ADDR_W-1:0]   reg_addr,
  input  wire logic [7:0]                    reg_wdata,
  output logic      [7:0]                    reg_rdata_q,
  input  wire vdlc_pkg::vdlc_fmt_t           out_format,
  input  wire logic                          field_start,
  input  wire logic                          field_end,
  input  wire logic                          line_active,
  input  wire logic                          video_active,
  input  wire logic                          pixel_tick,
  input  wire logic                          line_lock_pixel,
  input  wire logic                          narrow_valid,
  input  wire logic                          hsync_miss,
  input  wire logic                          hsync_seen,
  input  wire logic                          vsync_miss,
  input  wire logic                          vsync_seen,
  input  wire logic                          gain_lock_achieved,
  output logic                               square_pixel_q,
  output logic                               timing_freeze_q,
  output logic                               pixel_valid_strobe_q,
  output logic                               pixel_valid_clk_gate_q,
  output logic                               h_acquire_q,
  output logic                               v_acquire_q,
  output logic      [1:0]                    clock_freq_code_q,
  output vdlc_pkg::vdlc_gain_t               gain_sel_q,
  output logic                               aaf_bypass_q,
  output logic      [3:0]                    input_route_q
);
  import vdlc_pkg::*;

  typedef struct packed {
    logic [7:0] lock_reg;
    logic [7:0] ain_reg;
    logic [7:0] rdata;
    logic       freeze;
    logic       recover;
    logic       toggle;
    logic       pv;
    logic       pv_gate;
    logic       square;
    logic       h_acq;
    logic       v_acq;
    logic [1:0] clkf;
    logic [1:0] gain;
    logic       aaf;
    logic [3:0] route;
  } vdlc_st_t;

  vdlc_st_t     st_q;
  vdlc_st_t     st_d;
  vdlc_lock_if  lk ();
  logic         sync_loss;
  logic         wide_fmt;
  logic [1:0]   gain_fld;
  logic [1:0]   policy;
  logic [2:0]   insel;

  // ****************************************
  // lock monitor
  // ****************************************
  assign lk.h_one = st_q.lock_reg[HMISS_BIT];
  assign lk.v_one = st_q.lock_reg[VMISS_BIT];

  vdlc_lock_mon u_mon (
    .sys_clk    (sys_clk),
    .rst_n      (rst_n),
    .hsync_miss (hsync_miss),
    .hsync_seen (hsync_seen),
    .vsync_miss (vsync_miss),
    .vsync_seen (vsync_seen),
    .lk         (lk.mon)
  );

  assign sync_loss = lk.h_acq | lk.v_acq;
  assign gain_fld  = st_q.ain_reg[GAIN_LSB +: 2];
  assign policy    = st_q.ain_reg[POLICY_LSB +: 2];
  assign insel     = st_q.ain_reg[INSEL_LSB +: 3];
  assign wide_fmt  = (out_format == VDLC_FMT_YC16) ||
                     (out_format == VDLC_FMT_RGB15) ||
                     (out_format == VDLC_FMT_RGB16);

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    st_d = st_q;
    // register writes
    if (reg_wr && reg_addr == LOCK_CTRL_OFS) begin
      st_d.lock_reg = reg_wdata;
    end else if (reg_wr && reg_addr == AIN_CTRL_OFS) begin
      st_d.ain_reg = reg_wdata;
    end
    // sync loss gain handling; hardware update wins over a host write
    if (sync_loss && gain_fld != VDLC_GAIN_AUTO) begin
      case (policy)
        VDLC_LOSS_AUTO: begin
          st_d.ain_reg[GAIN_LSB +: 2] = VDLC_GAIN_AUTO;
        end
        VDLC_LOSS_KEEP: begin
          st_d.ain_reg[GAIN_LSB +: 2] = gain_fld;
        end
        VDLC_LOSS_AGC_THEN_FIX: begin
          st_d.recover = 1'b1;
          if (gain_fld == VDLC_GAIN_FREEZE) begin
            st_d.ain_reg[GAIN_LSB +: 2] = VDLC_GAIN_AUTO;
          end else begin
            st_d.ain_reg[GAIN_LSB +: 2] = gain_fld;
          end
        end
        default: begin
          st_d.recover = st_q.recover;
        end
      endcase
    end else if (gain_lock_achieved) begin
      st_d.recover = 1'b0;
    end
    // read data, unmapped reads return zero
    if (reg_rd && reg_addr == LOCK_CTRL_OFS) begin
      st_d.rdata = st_q.lock_reg;
    end else if (reg_rd && reg_addr == AIN_CTRL_OFS) begin
      st_d.rdata = st_q.ain_reg;
    end else if (reg_rd) begin
      st_d.rdata = 8'h00;
    end
    // output timing freeze at field boundaries
    if (!st_q.freeze && st_q.lock_reg[FREEZE_BIT] && field_end) begin
      st_d.freeze = 1'b1;
    end else if (st_q.freeze && !st_q.lock_reg[FREEZE_BIT] &&
                 field_start) begin
      st_d.freeze = 1'b0;
    end
    // pixel valid strobe
    st_d.toggle  = pixel_tick ? ~st_q.toggle : st_q.toggle;
    st_d.pv_gate = 1'b0;
    if (wide_fmt) begin
      if (!st_q.lock_reg[LTC_BIT] && !(line_active && video_active)) begin
        st_d.pv = 1'b0;
      end else if (st_q.lock_reg[DUTY_BIT]) begin
        st_d.pv = line_lock_pixel;
      end else begin
        st_d.pv = st_q.toggle;
      end
    end else begin
      st_d.pv      = narrow_valid;
      st_d.pv_gate = st_q.lock_reg[LTC_BIT];
    end
    // static controls, acquisition pulses and gain select
    st_d.square = st_q.lock_reg[ASPECT_BIT];
    st_d.clkf   = st_q.lock_reg[CLKF_LSB +: 2];
    st_d.aaf    = st_q.ain_reg[AAF_BIT];
    st_d.h_acq  = lk.h_acq;
    st_d.v_acq  = lk.v_acq;
    st_d.gain   = st_q.recover ? VDLC_GAIN_AUTO : gain_fld;
    case (insel)
      3'h0:    st_d.route = 4'h1;
      3'h1:    st_d.route = 4'h2;
      3'h2:    st_d.route = 4'h4;
      3'h3:    st_d.route = 4'h8;
      default: st_d.route = 4'h0;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q          <= '0;
      st_q.lock_reg <= LOCK_CTRL_RST;
      st_q.ain_reg  <= AIN_CTRL_RST;
      st_q.clkf     <= LOCK_CTRL_RST[CLKF_LSB +: 2];
      st_q.gain     <= VDLC_GAIN_AUTO;
      st_q.route    <= 4'h1;
    end else begin
      st_q <= st_d;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign reg_rdata_q            = st_q.rdata;
  assign square_pixel_q         = st_q.square;
  assign timing_freeze_q        = st_q.freeze;
  assign pixel_valid_strobe_q   = st_q.pv;
  assign pixel_valid_clk_gate_q = st_q.pv_gate;
  assign h_acquire_q            = st_q.h_acq;
  assign v_acquire_q            = st_q.v_acq;
  assign clock_freq_code_q      = st_q.clkf;
  assign gain_sel_q             = vdlc_gain_t'(st_q.gain);
  assign aaf_bypass_q           = st_q.aaf;
  assign input_route_q          = st_q.route;

  // ****************************************
  // assertions
  // ****************************************
  sequence s_freeze_req;
    !st_q.freeze && st_q.lock_reg[FREEZE_BIT] && field_end;
  endsequence
  sequence s_thaw_req;
    st_q.freeze && !st_q.lock_reg[FREEZE_BIT] && field_start;
  endsequence
  sequence s_loss_no_wr;
    sync_loss && !(reg_wr && reg_addr == AIN_CTRL_OFS);
  endsequence
  sequence s_even_mode;
    wide_fmt && !st_q.lock_reg[DUTY_BIT] &&
    (st_q.lock_reg[LTC_BIT] || (line_active && video_active));
  endsequence
  sequence s_line_mode;
    wide_fmt && st_q.lock_reg[DUTY_BIT] &&
    (st_q.lock_reg[LTC_BIT] || (line_active && video_active));
  endsequence

  aspect_out_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    ##1 square_pixel_q == $past(st_q.lock_reg[ASPECT_BIT]))
    else $error("aspect output does not follow register");
  freeze_enter_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    s_freeze_req |=> timing_freeze_q)
    else $error("timing not frozen at field end");
  freeze_hold_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    timing_freeze_q && !field_start |=> timing_freeze_q)
    else $error("freeze released outside field start");
  freeze_exit_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    s_thaw_req |=> !timing_freeze_q)
    else $error("timing not resumed at field start");
  duty_line_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    s_line_mode |=> pixel_valid_strobe_q == $past(line_lock_pixel))
    else $error("strobe does not follow line lock timing");
  duty_even_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    s_even_mode ##1 s_even_mode
    |=> pixel_valid_strobe_q ==
        ($past(pixel_valid_strobe_q) ^ $past(pixel_tick, 2)))
    else $error("even duty strobe did not toggle per pixel");
  wide_gap_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    wide_fmt && !st_q.lock_reg[LTC_BIT] && !line_active
    |=> !pixel_valid_strobe_q)
    else $error("strobe active outside active lines");
  clk_gate_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    !wide_fmt && st_q.lock_reg[LTC_BIT] |=> pixel_valid_clk_gate_q)
    else $error("clock gating flag missing in narrow mode");
  narrow_pass_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    !wide_fmt |=> pixel_valid_strobe_q == $past(narrow_valid))
    else $error("narrow mode strobe timing changed");
  auto_ignore_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    s_loss_no_wr ##0 gain_fld == VDLC_GAIN_AUTO |=> $stable(st_q.ain_reg))
    else $error("loss policy acted while gain mode automatic");
  gain_auto_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    s_loss_no_wr ##0 policy == VDLC_LOSS_AUTO
    |=> gain_fld == VDLC_GAIN_AUTO ##1 gain_sel_q == VDLC_GAIN_AUTO)
    else $error("gain mode not returned to automatic");
  gain_keep_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    s_loss_no_wr ##0 policy == VDLC_LOSS_KEEP |=> $stable(gain_fld))
    else $error("gain mode changed under keep policy");
  loss_freeze_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    s_loss_no_wr ##0 policy == VDLC_LOSS_AGC_THEN_FIX
    ##0 gain_fld == VDLC_GAIN_FREEZE |=> gain_fld == VDLC_GAIN_AUTO)
    else $error("frozen gain mode not reset after sync loss");
  agc_recover_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    sync_loss && policy == VDLC_LOSS_AGC_THEN_FIX &&
    gain_fld != VDLC_GAIN_AUTO |=> ##1 gain_sel_q == VDLC_GAIN_AUTO)
    else $error("automatic gain not used after sync loss");
  unity_gain_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    !st_q.recover && gain_fld == VDLC_GAIN_UNITY
    |=> gain_sel_q == VDLC_GAIN_UNITY)
    else $error("unity gain not selected");
  aaf_out_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    ##1 aaf_bypass_q == $past(st_q.ain_reg[AAF_BIT]))
    else $error("filter bypass does not follow register");
  route_luma_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    insel == 3'h3 |=> input_route_q == 4'h8)
    else $error("luma chroma input not routed");
  read_back_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    reg_rd && reg_addr == AIN_CTRL_OFS
    |=> reg_rdata_q == $past(st_q.ain_reg))
    else $error("analog register read back wrong");
  read_lock_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    reg_rd && reg_addr == LOCK_CTRL_OFS
    |=> reg_rdata_q == $past(st_q.lock_reg))
    else $error("lock register read back wrong");
endmodule
`default_nettype wire

// ---- testbench/vdlc_host_model.sv ----
// host model driving decoded byte reads and writes of the register port
// assumes the caller enters each task just after a rising sys_clk edge
`timescale 1ns/10ps
`default_nettype none
module vdlc_host_model (
  input  wire logic       sys_clk,
  output var  logic       reg_wr,
  output var  logic       reg_rd,
  output var  logic [7:0] reg_addr,
  output var  logic [7:0] reg_wdata
);
  // ****************************************
  // transfers
  // ****************************************
  initial begin
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_addr  = 8'h00;
    reg_wdata = 8'h00;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    if (a == 8'h04 && d[1:0] == 2'h3) d[1:0] = 2'h1;
    if (a == 8'h05 && d[7:6] == 2'h3) d[7:6] = 2'h1;
    if (a == 8'h05) d[2] = 1'b0;
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr    <= 1'b0;
    reg_addr  <= ~a;
    reg_wdata <= ~d;
    @(posedge sys_clk);
  endtask
  task automatic rd(input logic [7:0] a);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd   <= 1'b0;
    reg_addr <= ~a;
    @(posedge sys_clk);
  endtask
endmodule
`default_nettype wire

// ---- testbench/vdlc_top_bench.sv ----
// self checking bench for the lock and analog input control registers
// assumes the host model owns the register port
`timescale 1ns/10ps
`default_nettype none
module vdlc_top_bench;
  import vdlc_pkg::*;
  // ****************************************
  // signals and models
  // ****************************************
  logic sys_clk = 1'b0, rst_n = 1'b0;
  logic reg_wr, reg_rd;
  logic [7:0] reg_addr, reg_wdata, reg_rdata_q, exp_q[$];
  vdlc_fmt_t out_format = VDLC_FMT_YC16;
  logic field_start = 0, field_end = 0, line_active = 0, video_active = 0;
  logic pixel_tick = 0, line_lock_pixel = 0, narrow_valid = 0;
  logic hsync_miss = 0, hsync_seen = 0, vsync_miss = 0, vsync_seen = 0;
  logic gain_lock_achieved = 0, square_pixel_q, timing_freeze_q;
  logic pixel_valid_strobe_q, pixel_valid_clk_gate_q, h_acquire_q;
  logic v_acquire_q, aaf_bypass_q;
  logic [1:0] clock_freq_code_q, rd_p = 2'b00;
  vdlc_gain_t gain_sel_q;
  logic [3:0] input_route_q;
  logic k1, k2, p1;
  logic [31:0] rng = 32'd95802;
  int error_cnt = 0, tests_run = 0, cyc = 0, hacq_n = 0, vacq_n = 0, h0;
  logic [7:0] tbl [10] = '{8'h30, 8'h10, 8'h60, 8'h60, 8'hb0, 8'h90,
                           8'h50, 8'h50, 8'ha0, 8'ha0};
  always #20 sys_clk = ~sys_clk;
  vdlc_host_model host (.sys_clk(sys_clk), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata));
  vdlc_top DUT (.sys_clk(sys_clk), .rst_n(rst_n), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata_q(reg_rdata_q), .out_format(out_format),
    .field_start(field_start), .field_end(field_end),
    .line_active(line_active), .video_active(video_active),
    .pixel_tick(pixel_tick), .line_lock_pixel(line_lock_pixel),
    .narrow_valid(narrow_valid), .hsync_miss(hsync_miss),
    .hsync_seen(hsync_seen), .vsync_miss(vsync_miss),
    .vsync_seen(vsync_seen), .gain_lock_achieved(gain_lock_achieved),
    .square_pixel_q(square_pixel_q), .timing_freeze_q(timing_freeze_q),
    .pixel_valid_strobe_q(pixel_valid_strobe_q),
    .pixel_valid_clk_gate_q(pixel_valid_clk_gate_q),
    .h_acquire_q(h_acquire_q), .v_acquire_q(v_acquire_q),
    .clock_freq_code_q(clock_freq_code_q), .gain_sel_q(gain_sel_q),
    .aaf_bypass_q(aaf_bypass_q), .input_route_q(input_route_q));
  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    tests_run++;
    if (g !== e) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic rdx(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    host.rd(a);
  endtask
  task automatic w(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  task automatic miss(input bit v);
    if (v) vsync_miss <= 1'b1;
    else hsync_miss <= 1'b1;
    @(posedge sys_clk);
    vsync_miss <= 1'b0;
    hsync_miss <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic conclude();
    $display("checks %0d errors %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // ****************************************
  // watchers and random inputs
  // ****************************************
  always @(posedge sys_clk) begin
    rd_p <= {rd_p[0], reg_rd};
    rng <= xs(rng);
    pixel_tick <= rng[0];
    line_lock_pixel <= rng[1];
    narrow_valid <= rng[2];
    if (h_acquire_q === 1'b1) hacq_n <= hacq_n + 1;
    if (v_acquire_q === 1'b1) vacq_n <= vacq_n + 1;
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      conclude();
    end
  end
  always @(negedge sys_clk) if (rd_p[1]) chk("rdata", exp_q.pop_front(), reg_rdata_q);
  // ****************************************
  // scenarios
  // ****************************************
  initial begin
    w(12);
    rst_n <= 1'b1;
    w(2);
    rdx(8'h04, LOCK_CTRL_RST);
    rdx(8'h05, AIN_CTRL_RST);
    chk("route", 8'h01, {4'h0, input_route_q});
    chk("clkcode", 8'h01, {6'h0, clock_freq_code_q});
    host.wr(8'h07, 8'hff);
    rdx(8'h07, 8'h00);
    rdx(8'h04, LOCK_CTRL_RST);
    for (int i = 0; i < 4; i++) begin
      h0 = {rng[7:2], rng[1] ? 2'h2 : {1'b0, rng[0]}};
      host.wr(8'h04, h0[7:0]);
      rdx(8'h04, h0[7:0]);
      chk("square", {7'h0, h0[7]}, {7'h0, square_pixel_q});
      chk("clkcode", {6'h0, h0[1:0]}, {6'h0, clock_freq_code_q});
    end
    for (int i = 0; i < 4; i++) begin
      host.wr(8'h05, {4'h1, i[0], 1'b0, i[1:0]});
      w(2);
      chk("route", 8'h01 << i, {4'h0, input_route_q});
      chk("aaf", {7'h0, i[0]}, {7'h0, aaf_bypass_q});
    end
    for (int g = 0; g < 4; g++) begin
      host.wr(8'h05, {2'b01, g[1:0], 4'h0});
      w(2);
      chk("gain", {6'h0, g[1:0]}, {6'h0, gain_sel_q});
    end
    host.wr(8'h04, 8'h01);
    h0 = hacq_n;
    repeat (11) miss(0);
    w(3);
    chk("hacq11", h0[7:0], hacq_n[7:0]);
    hsync_seen <= 1'b1;
    w(1);
    hsync_seen <= 1'b0;
    repeat (11) miss(0);
    w(3);
    chk("hacq22", h0[7:0], hacq_n[7:0]);
    miss(0);
    w(3);
    chk("hacq12", h0[7:0] + 8'h1, hacq_n[7:0]);
    h0 = vacq_n;
    repeat (2) miss(1);
    w(3);
    chk("vacq2", h0[7:0], vacq_n[7:0]);
    vsync_seen <= 1'b1;
    w(1);
    vsync_seen <= 1'b0;
    repeat (2) miss(1);
    w(3);
    chk("vacq4", h0[7:0], vacq_n[7:0]);
    miss(1);
    w(3);
    chk("vacq3", h0[7:0] + 8'h1, vacq_n[7:0]);
    host.wr(8'h04, 8'h0d);
    miss(1);
    w(3);
    chk("vacq1", h0[7:0] + 8'h2, vacq_n[7:0]);
    for (int i = 0; i < 10; i += 2) begin
      host.wr(8'h05, tbl[i]);
      miss(0);
      w(3);
      rdx(8'h05, tbl[i+1]);
    end
    chk("gain", {6'h0, VDLC_GAIN_AUTO}, {6'h0, gain_sel_q});
    gain_lock_achieved <= 1'b1;
    w(1);
    gain_lock_achieved <= 1'b0;
    w(3);
    chk("gain", {6'h0, VDLC_GAIN_FIXED}, {6'h0, gain_sel_q});
    host.wr(8'h04, 8'h49);
    w(2);
    chk("freeze", 8'h00, {7'h0, timing_freeze_q});
    field_end <= 1'b1;
    w(1);
    field_end <= 1'b0;
    w(3);
    chk("freeze", 8'h01, {7'h0, timing_freeze_q});
    host.wr(8'h04, 8'h09);
    w(2);
    chk("freeze", 8'h01, {7'h0, timing_freeze_q});
    field_start <= 1'b1;
    w(1);
    field_start <= 1'b0;
    w(3);
    chk("freeze", 8'h00, {7'h0, timing_freeze_q});
    out_format <= VDLC_FMT_YC8;
    host.wr(8'h04, 8'h19);
    w(3);
    chk("clkgate", 8'h01, {7'h0, pixel_valid_clk_gate_q});
    host.wr(8'h04, 8'h09);
    w(3);
    chk("clkgate", 8'h00, {7'h0, pixel_valid_clk_gate_q});
    out_format <= VDLC_FMT_RGB16;
    w(4);
    chk("strobe", 8'h00, {7'h0, pixel_valid_strobe_q});
    host.wr(8'h04, 8'h39); // whole line with line lock strobe
    for (int i = 0; i < 16; i++) begin
      @(negedge sys_clk);
      if (i > 0)
        chk("line", {7'h0, k1}, {7'h0, pixel_valid_strobe_q});
      k1 = line_lock_pixel;
    end
    @(posedge sys_clk);
    line_active <= 1'b1;
    video_active <= 1'b1;
    host.wr(8'h04, 8'h09);
    for (int i = 0; i < 16; i++) begin
      @(negedge sys_clk);
      if (i > 1)
        chk("tog", {7'h0, p1 ^ k2}, {7'h0, pixel_valid_strobe_q});
      k2 = k1;
      k1 = pixel_tick;
      p1 = pixel_valid_strobe_q;
    end
    w(4);
    conclude();
  end
endmodule
`default_nettype wire
